// >>> cfr_regs.sv
// cfr_regs: peripheral request flags, reset-cause status and 13-bit
// program counter load logic behind an axi4-lite slave.
// assumes peripheral events are one-cycle pulses on core_clk.
`timescale 1ns/1ns
module cfr_regs #(
  parameter bit REDUCED = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic por_event,
  input wire logic bor_event,
  input wire logic bor_enable,
  input wire logic conv_done,
  input wire logic capture_event,
  input wire logic compare_match,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  input wire logic period_match,
  input wire logic timer_overflow,
  input wire logic jump_valid,
  input wire logic [10:0] jump_operand,
  input wire logic [cfr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cfr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [12:0] pc_out,
  output logic irq
);
  import cfr_pkg::*;

  // whole block state; one flop bank, one next-state copy
  typedef struct packed {
    logic [1:0] c1_sync;
    logic [1:0] c2_sync;
    logic c1_prev;
    logic c2_prev;
    logic [1:0] sync_fill;
    logic [7:0] flags;
    logic [7:0] irq_en;
    logic [1:0] pwr;
    logic [12:0] pc;
    logic [4:0] latch;
    cfr_ccp_mode_t ccp_mode;
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic irq;
  } cfr_state_t;

  cfr_state_t s_q;
  cfr_state_t s_d;

  // known register word; flags, pwr, pcl, latch, pc, en, clr, ctrl, jump
  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return a == OFF_FLAGS || a == OFF_PWR || a == OFF_PCL ||
      a == OFF_LATCH || a == OFF_PC || a == OFF_IRQ_EN ||
      a == OFF_IRQ_CLR || a == OFF_CTRL || a == OFF_JUMP;
  endfunction

  function automatic logic [7:0] impl_mask(input logic reduced);
    return reduced ? (FLAGS_IMPL & ~FLAGS_FULL_ONLY) : FLAGS_IMPL;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] ev;
  logic [7:0] mask;
  logic do_wr;
  logic [31:0] wd;
  logic [7:0] pcl_rd;
  logic primed;

  always_comb begin
    s_d = s_q;
    mask = impl_mask(REDUCED);
    pcl_rd = s_q.pc[7:0];
    // comparator outputs are asynchronous to core_clk
    s_d.c1_sync = {s_q.c1_sync[0], cmp1_out};
    s_d.c2_sync = {s_q.c2_sync[0], cmp2_out};
    s_d.c1_prev = s_q.c1_sync[1];
    s_d.c2_prev = s_q.c2_sync[1];
    primed = s_q.sync_fill == SYNC_FILL;
    // the first samples after reset would look like a pin edge
    if (!primed) begin
      s_d.sync_fill = s_q.sync_fill + 2'h1;
    end

    ev = 8'h00;
    ev[BIT_CONV] = conv_done;
    ev[BIT_CAPCMP] = (s_q.ccp_mode == CCP_CAPTURE && capture_event) ||
      (s_q.ccp_mode == CCP_COMPARE && compare_match);
    ev[BIT_CMP2] = primed && (s_q.c2_sync[1] ^ s_q.c2_prev);
    ev[BIT_CMP1] = primed && (s_q.c1_sync[1] ^ s_q.c1_prev);
    ev[BIT_PERIOD] = period_match;
    ev[BIT_OVF] = timer_overflow;

    // write channel: address and data may arrive in either order
    if (s_axi_awvalid && !s_q.aw_held) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_held) begin
      s_d.w_held = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    do_wr = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    wd = s_q.wdata;

    if (do_wr) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = addr_known(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_q.wstrb[0]) begin
        unique case (s_q.awaddr)
          // writing zero clears; writing one leaves the flag alone
          OFF_FLAGS: s_d.flags = s_q.flags & wd[7:0];
          OFF_IRQ_CLR: s_d.flags = s_q.flags & ~wd[7:0];
          OFF_IRQ_EN: s_d.irq_en = wd[7:0] & mask;
          OFF_PWR: s_d.pwr = wd[1:0];
          OFF_LATCH: s_d.latch = wd[4:0];
          OFF_PCL: s_d.pc = {s_q.latch, wd[7:0]};
          OFF_CTRL: s_d.ccp_mode = cfr_ccp_mode_t'(wd[1:0]);
          default: s_d.pc = s_q.pc;
        endcase
      end
    end
    // response stands until the master takes it
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // jump outranks a same-cycle low-byte write; latch untouched
    if (jump_valid) begin
      s_d.pc = {s_q.latch[4:3], jump_operand};
    end

    // event set wins over a same-cycle software clear
    s_d.flags = (s_d.flags | ev) & mask;

    // reset-cause bits clear on their own reset event
    if (por_event) begin
      s_d.pwr[BIT_POR] = 1'b0;
    end
    if (bor_event) begin
      s_d.pwr[BIT_BOR] = 1'b0;
    end
    if (por_event || bor_event) begin
      s_d.pc = PC_RST;
    end

    // read data captured at the address handshake, held until rready
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFF_FLAGS: s_d.rdata = {24'h000000, s_q.flags & mask};
        OFF_PWR: s_d.rdata = {30'h0, s_q.pwr[BIT_POR],
          s_q.pwr[BIT_BOR] & bor_enable};
        OFF_PCL: s_d.rdata = {24'h000000, pcl_rd};
        OFF_LATCH: s_d.rdata = {27'h0, s_q.latch};
        OFF_PC: s_d.rdata = {24'h000000, pcl_rd};
        OFF_IRQ_EN: s_d.rdata = {24'h000000, s_q.irq_en};
        OFF_CTRL: s_d.rdata = {30'h0, s_q.ccp_mode};
        default: s_d.rdata = 32'h00000000;
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // readies come from their own flops, not through an inverter
    s_d.aw_rdy = !s_d.aw_held;
    s_d.w_rdy = !s_d.w_held;
    s_d.ar_rdy = !s_d.rvalid;
    s_d.irq = |(s_d.flags & s_d.irq_en);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.flags <= FLAGS_RST;
      s_q.pwr <= PWR_RST;
      s_q.pc <= PC_RST;
      s_q.latch <= LATCH_RST;
      s_q.ccp_mode <= cfr_ccp_mode_t'(CCP_MODE_RST);
      // readies high out of reset so the first request is taken
      s_q.aw_rdy <= READY_RST;
      s_q.w_rdy <= READY_RST;
      s_q.ar_rdy <= READY_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = s_q.aw_rdy;
  assign s_axi_wready = s_q.w_rdy;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.ar_rdy;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign pc_out = s_q.pc;
  assign irq = s_q.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks on the rules this block carries out
  property p_conv;
    @(posedge core_clk) disable iff (!rst_b)
      conv_done && !REDUCED |=> s_q.flags[BIT_CONV];
  endproperty
  a_conv: assert property (p_conv) else $error("conv flag not set");

  property p_cap;
    @(posedge core_clk) disable iff (!rst_b)
      capture_event && s_q.ccp_mode == CCP_CAPTURE && !REDUCED
      |=> s_q.flags[BIT_CAPCMP];
  endproperty
  a_cap: assert property (p_cap) else $error("capture flag not set");

  property p_pwm;
    @(posedge core_clk) disable iff (!rst_b)
      s_q.ccp_mode == CCP_PWM && !s_q.flags[BIT_CAPCMP] && !do_wr
      |=> !s_q.flags[BIT_CAPCMP];
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm set ccp flag");

  property p_cmp1;
    @(posedge core_clk) disable iff (!rst_b)
      $changed(s_q.c1_sync[1]) && s_q.sync_fill == SYNC_FILL
      |=> s_q.flags[BIT_CMP1];
  endproperty
  a_cmp1: assert property (p_cmp1) else $error("cmp1 flag missed");

  property p_ovf;
    @(posedge core_clk) disable iff (!rst_b)
      timer_overflow |=> s_q.flags[BIT_OVF];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag missed");

  property p_unimpl;
    @(posedge core_clk) disable iff (!rst_b)
      s_q.flags[7] == 1'b0 && s_q.flags[2] == 1'b0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("reserved bit set");

  property p_por;
    @(posedge core_clk) disable iff (!rst_b)
      por_event |=> s_q.pwr[BIT_POR] == 1'b0 && s_q.pc == PC_RST;
  endproperty
  a_por: assert property (p_por) else $error("por not cleared");

  property p_pcl;
    @(posedge core_clk) disable iff (!rst_b)
      do_wr && s_q.awaddr == OFF_PCL && s_q.wstrb[0] && !jump_valid &&
      !por_event && !bor_event
      |=> s_q.pc == {$past(s_q.latch), $past(s_q.wdata[7:0])};
  endproperty
  a_pcl: assert property (p_pcl) else $error("pcl load wrong");

  property p_jump;
    @(posedge core_clk) disable iff (!rst_b)
      jump_valid && !por_event && !bor_event
      |=> s_q.pc[12:11] == $past(s_q.latch[4:3]) &&
        s_q.pc[10:0] == $past(jump_operand) &&
        (s_q.latch == $past(s_q.latch) ||
        ($past(do_wr) && $past(s_q.awaddr) == OFF_LATCH));
  endproperty
  a_jump: assert property (p_jump) else $error("jump load wrong");

  property p_cmp2;
    @(posedge core_clk) disable iff (!rst_b)
      $changed(s_q.c2_sync[1]) && s_q.sync_fill == SYNC_FILL
      |=> s_q.flags[BIT_CMP2];
  endproperty
  a_cmp2: assert property (p_cmp2) else $error("cmp2 flag missed");

  property p_cmp;
    @(posedge core_clk) disable iff (!rst_b)
      compare_match && s_q.ccp_mode == CCP_COMPARE && !REDUCED
      |=> s_q.flags[BIT_CAPCMP];
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare flag not set");

  property p_period;
    @(posedge core_clk) disable iff (!rst_b)
      period_match && !REDUCED |=> s_q.flags[BIT_PERIOD];
  endproperty
  a_period: assert property (p_period) else $error("period missed");

  // no flag may drop without a software write
  property p_sticky;
    @(posedge core_clk) disable iff (!rst_b)
      !do_wr |=> (s_q.flags & $past(s_q.flags)) == $past(s_q.flags);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  property p_reduced;
    @(posedge core_clk) disable iff (!rst_b)
      REDUCED |-> (s_q.flags & FLAGS_FULL_ONLY) == 8'h00 &&
        (s_q.irq_en & FLAGS_FULL_ONLY) == 8'h00;
  endproperty
  a_reduced: assert property (p_reduced) else $error("hidden bit set");

  property p_bor;
    @(posedge core_clk) disable iff (!rst_b)
      bor_event |=> s_q.pwr[BIT_BOR] == 1'b0 && s_q.pc == PC_RST;
  endproperty
  a_bor: assert property (p_bor) else $error("bor not cleared");

  property p_bor_off;
    @(posedge core_clk) disable iff (!rst_b)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_PWR &&
      !bor_enable |=> s_axi_rdata[BIT_BOR] == 1'b0;
  endproperty
  a_bor_off: assert property (p_bor_off) else $error("bor not masked");

  property p_pcl_rd;
    @(posedge core_clk) disable iff (!rst_b)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_PCL
      |=> s_axi_rdata == {24'h000000, $past(s_q.pc[7:0])};
  endproperty
  a_pcl_rd: assert property (p_pcl_rd) else $error("pcl read bad");

  property p_pch;
    @(posedge core_clk) disable iff (!rst_b)
      !jump_valid && !por_event && !bor_event &&
      !(do_wr && s_q.awaddr == OFF_PCL && s_q.wstrb[0])
      |=> $stable(s_q.pc[12:8]);
  endproperty
  a_pch: assert property (p_pch) else $error("pc upper changed");
endmodule

// >>> cfr_pkg.sv
// cfr_pkg: register map, field positions and reset values of the core
// flag / reset-status / program counter register block.
// assumes a 32-bit axi4-lite register bus, one register per word.
package cfr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_FLAGS = 8'h00;
  localparam logic [7:0] OFF_PWR = 8'h04;
  localparam logic [7:0] OFF_PCL = 8'h08;
  localparam logic [7:0] OFF_LATCH = 8'h0C;
  localparam logic [7:0] OFF_PC = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFF_CTRL = 8'h1C;
  localparam logic [7:0] OFF_JUMP = 8'h20;

  localparam int unsigned BIT_CONV = 6;
  localparam int unsigned BIT_CAPCMP = 5;
  localparam int unsigned BIT_CMP2 = 4;
  localparam int unsigned BIT_CMP1 = 3;
  localparam int unsigned BIT_PERIOD = 1;
  localparam int unsigned BIT_OVF = 0;
  localparam logic [7:0] FLAGS_IMPL = 8'h7B;
  localparam logic [7:0] FLAGS_FULL_ONLY = 8'h62;
  localparam int unsigned BIT_POR = 1;
  localparam int unsigned BIT_BOR = 0;

  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [1:0] PWR_RST = 2'h0;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [4:0] LATCH_RST = 5'h00;
  localparam logic [1:0] CCP_MODE_RST = 2'h0;
  localparam logic READY_RST = 1'b1;
  localparam logic [1:0] SYNC_FILL = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CCP_OFF,
    CCP_CAPTURE,
    CCP_COMPARE,
    CCP_PWM
  } cfr_ccp_mode_t;
endpackage

// >>> tb_cfr_regs.sv
// tb_cfr_regs: self-checking bench for the flag, reset-status and pc block.
// assumes the block answers on axi4-lite and events are one-cycle pulses.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  err_count++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_cfr_regs;
  import cfr_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic bor_enable = 1'b1;
  logic cmp1_out = 1'b0;
  logic cmp2_out = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [10:0] jump_operand = 11'h000;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [12:0] pc_out;
  logic [1:0] resp;
  logic [31:0] rd;
  logic [31:0] rdata_r, rd_r;
  int err_count = 0;
  int tests_run = 0;

  cfr_regs i_cfr_regs (.core_clk(core_clk), .rst_b(rst_b),
    .por_event(ev[5]), .bor_event(ev[6]), .bor_enable(bor_enable),
    .conv_done(ev[0]), .capture_event(ev[1]), .compare_match(ev[2]),
    .cmp1_out(cmp1_out), .cmp2_out(cmp2_out), .period_match(ev[3]),
    .timer_overflow(ev[4]), .jump_valid(ev[7]),
    .jump_operand(jump_operand), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pc_out(pc_out), .irq(irq));

  // reduced variant shares every input; only its read data is watched
  cfr_regs #(.REDUCED(1'b1)) i_cfr_regs_reduced (.core_clk(core_clk),
    .rst_b(rst_b), .por_event(ev[5]), .bor_event(ev[6]),
    .bor_enable(bor_enable), .conv_done(ev[0]), .capture_event(ev[1]),
    .compare_match(ev[2]), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
    .period_match(ev[3]), .timer_overflow(ev[4]), .jump_valid(ev[7]),
    .jump_operand(jump_operand), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
    .s_axi_rdata(rdata_r), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready(rready), .pc_out(), .irq());

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  task complete_run;
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // bus tasks: readies are sampled as seen just before each edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge core_clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge core_clk);
      if (awvalid && awready && !aw_done) begin
        aw_done = 1'b1; awvalid <= 1'b0;
      end
      if (wvalid && wready && !w_done) begin
        w_done = 1'b1; wvalid <= 1'b0;
      end
      if (bvalid) begin
        resp = bresp; bready <= 1'b0; break;
      end
    end
    if (n == 200) begin err_count++; complete_run(); end
  endtask

  task rdw(input logic [7:0] a);
    int n;
    logic ar_done;
    ar_done = 1'b0;
    @(posedge core_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge core_clk);
      if (arvalid && arready && !ar_done) begin
        ar_done = 1'b1; arvalid <= 1'b0;
      end
      if (rvalid) begin
        rd_r = rdata_r;
        rd = rdata; resp = rresp; rready <= 1'b0; break;
      end
    end
    if (n == 200) begin err_count++; complete_run(); end
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e);
    rdw(a);
    `CHK("rdata", e, rd)
  endtask

  task pulse(input int i);
    @(posedge core_clk);
    ev[i] <= 1'b1;
    @(posedge core_clk);
    ev[i] <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    `CHK("pc_out", 13'h0000, pc_out)
    rchk(OFF_FLAGS, 32'h0);
    rchk(OFF_PWR, 32'h0);
    wr(OFF_CTRL, 32'h1);
    pulse(0); pulse(1); pulse(3); pulse(4);
    rchk(OFF_FLAGS, 32'h63);
    `CHK("reduced_flags", 32'h01, rd_r)
    wr(OFF_FLAGS, 32'hFF);
    rchk(OFF_FLAGS, 32'h63);
    wr(OFF_FLAGS, 32'h00);
    rchk(OFF_FLAGS, 32'h00);
    // compare mode ignores captures, pwm mode ignores both
    wr(OFF_CTRL, 32'h2);
    pulse(1); pulse(2);
    rchk(OFF_FLAGS, 32'h20);
    wr(OFF_FLAGS, 32'h00);
    wr(OFF_CTRL, 32'h3);
    pulse(1); pulse(2);
    rchk(OFF_FLAGS, 32'h00);
    wr(OFF_CTRL, 32'h0);
    pulse(1); pulse(2);
    cmp1_out <= 1'b1;
    repeat (6) @(posedge core_clk);
    rchk(OFF_FLAGS, 32'h08);
    cmp2_out <= 1'b1;
    repeat (6) @(posedge core_clk);
    rchk(OFF_FLAGS, 32'h18);
    wr(OFF_FLAGS, 32'h00);
    rchk(OFF_FLAGS, 32'h00);
    wr(OFF_IRQ_EN, 32'h01);
    `CHK("irq", 1'b0, irq)
    pulse(4);
    repeat (3) @(posedge core_clk);
    `CHK("irq", 1'b1, irq)
    wr(OFF_IRQ_CLR, 32'h01);
    repeat (2) @(posedge core_clk);
    `CHK("irq", 1'b0, irq)
    rchk(OFF_FLAGS, 32'h00);
    wr(OFF_IRQ_EN, 32'h00);
    pulse(4);
    repeat (3) @(posedge core_clk);
    `CHK("irq", 1'b0, irq)
    rchk(OFF_FLAGS, 32'h01);
    wr(OFF_PWR, 32'h3);
    rchk(OFF_PWR, 32'h3);
    bor_enable <= 1'b0;
    rchk(OFF_PWR, 32'h2);
    bor_enable <= 1'b1;
    pulse(5);
    rchk(OFF_PWR, 32'h1);
    wr(OFF_PWR, 32'h3);
    pulse(6);
    rchk(OFF_PWR, 32'h2);
    wr(OFF_LATCH, 32'h1F);
    wr(OFF_PCL, 32'hAB);
    `CHK("pc_out", 13'h1FAB, pc_out)
    rchk(OFF_PCL, 32'hAB);
    rchk(OFF_PC, 32'hAB);
    pulse(6);
    repeat (2) @(posedge core_clk);
    `CHK("pc_out", 13'h0000, pc_out)
    wr(OFF_LATCH, 32'h1A);
    jump_operand <= 11'h123;
    pulse(7);
    repeat (2) @(posedge core_clk);
    `CHK("pc_out", 13'h1923, pc_out)
    rchk(OFF_LATCH, 32'h1A);
    rchk(8'h40, 32'h0);
    `CHK("rresp", RESP_SLVERR, resp)
    wr(8'h40, 32'h5);
    `CHK("bresp", RESP_SLVERR, resp)
    wr(OFF_JUMP, 32'h5);
    `CHK("bresp", RESP_OKAY, resp)
    rchk(OFF_JUMP, 32'h0);
    complete_run();
  end
endmodule
